// ==== mcc_main_clock_ctrl.sv ====
// Main clock controller: CPU clock prescaler, clock output select, time base
// flag and halt / active-halt sequencing, with an AXI4-Lite register port.
// Assumes REF_CLK is the divided oscillator clock and keeps running in this
// model; OSC_EN tells the pad oscillator when it may stop.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
module mcc_main_clock_ctrl
    import mcc_pkg::*;
#(
    parameter int TB_PERIOD_0 = 16000,
    parameter int TB_PERIOD_1 = 32000,
    parameter int TB_PERIOD_2 = 80000,
    parameter int TB_PERIOD_3 = 200000
) (
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    input  wire logic        CE,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // CPU side
    input  wire logic        HALT_REQ,
    input  wire logic        IRQ_PENDING,
    input  wire logic        CPU_IMASK_ACTIVE,
    output logic             CPU_CLK_EN,
    output logic             TB_IRQ,
    output logic             IMASK_FORCE,
    output logic [1:0]       IMASK_LEVEL,
    output logic             WAKE_IRQ_GO,
    output logic             WAKE_RESET_GO,
    // Options, watchdog, oscillator and pin
    input  wire logic        STAB_LONG,
    input  wire logic        WDG_ENABLE,
    input  wire logic        WATCHDOG_HALT_OPTION,
    output logic             WDG_RESET_REQ,
    output logic             OSC_EN,
    output logic             CLOCK_OUTPUT_PORT_PIN_SEL
);
    import mcc_pkg::*;

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic       rst_meta_ff;
    logic       rst_n;
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 3'h0;
            pin_sync_ff <= 3'h0;
        end else if (CE) begin
            pin_meta_ff <= {STAB_LONG, WDG_ENABLE, WATCHDOG_HALT_OPTION};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    wire stab_long_s = pin_sync_ff[2];
    wire wdg_en_s    = pin_sync_ff[1];
    wire wdg_opt_s   = pin_sync_ff[0];

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    mcc_ccs_t   ccs_ff;
    mcc_state_t state_ff;
    logic       cause_reset_ff;
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic       wstrb0_ff;
    logic       bvalid_ff;
    logic [1:0] bresp_ff;
    logic       rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;

    wire aw_take   = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take    = S_AXI_WVALID && S_AXI_WREADY;
    wire ar_take   = S_AXI_ARVALID && S_AXI_ARREADY;
    wire wr_fire   = aw_got_ff && w_got_ff && !bvalid_ff;
    wire wr_ccs    = wr_fire && (awaddr_ff == CCS_ADDR);
    wire wr_stat   = wr_fire && (awaddr_ff == STAT_ADDR);
    wire rd_ccs    = ar_take && (S_AXI_ARADDR == CCS_ADDR);
    wire rd_stat   = ar_take && (S_AXI_ARADDR == STAT_ADDR);
    wire rd_hit    = rd_ccs || rd_stat;
    wire [31:0] rd_word = rd_ccs  ? {24'h0, ccs_ff} :
                          rd_stat ? {29'h0, cause_reset_ff, state_ff} : 32'h0;

    assign S_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
    assign S_AXI_WREADY  = !w_got_ff && !bvalid_ff;
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RRESP   = rresp_ff;
    assign S_AXI_RDATA   = rdata_ff;

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= 8'h0;
            wdata_ff  <= 8'h0;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= AXI_OKAY;
        end else if (CE) begin
            if (aw_take) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_got_ff  <= 1'b1;
                wdata_ff  <= S_AXI_WDATA[7:0];
                wstrb0_ff <= S_AXI_WSTRB[0];
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (wr_ccs || wr_stat) ? AXI_OKAY : AXI_SLVERR;
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= AXI_OKAY;
            rdata_ff  <= 32'h0;
        end else if (CE) begin
            if (ar_take) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
                rdata_ff  <= rd_word;
            end else if (rvalid_ff && S_AXI_RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // CPU clock prescaler
    // ------------------------------------------------------------------
    logic [3:0] pre_cnt_ff;
    logic       slow_act_ff;
    logic [1:0] div_act_ff;

    // Terminal count 1,3,7,15 for /2,/4,/8,/16
    wire [3:0] pre_last = 4'((5'h2 << div_act_ff) - 5'h1);
    wire       pre_tick = !slow_act_ff || (pre_cnt_ff == pre_last);

    // New settings load only at a tick, so no shortened CPU period appears.
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_ff  <= 4'h0;
            slow_act_ff <= 1'b0;
            div_act_ff  <= 2'h0;
        end else if (CE) begin
            if (pre_tick) begin
                pre_cnt_ff  <= 4'h0;
                slow_act_ff <= ccs_ff.slow_mode_select;
                div_act_ff  <= ccs_ff.slow_clock_divider;
            end else begin
                pre_cnt_ff  <= pre_cnt_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    logic [17:0] tb_cnt_ff;
    logic [17:0] tb_last;

    always_comb begin
        case (ccs_ff.time_base_select)
            2'h0:    tb_last = 18'(TB_PERIOD_0 - 1);
            2'h1:    tb_last = 18'(TB_PERIOD_1 - 1);
            2'h2:    tb_last = 18'(TB_PERIOD_2 - 1);
            default: tb_last = 18'(TB_PERIOD_3 - 1);
        endcase
    end

    // Stopped with the oscillator in full halt and during restart.
    wire tb_run  = (state_ff == ST_RUN) || (state_ff == ST_ACT_HALT);
    wire tb_ovf  = tb_run && (tb_cnt_ff >= tb_last);

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tb_cnt_ff <= 18'h0;
        end else if (CE && tb_run) begin
            tb_cnt_ff <= tb_ovf ? 18'h0 : tb_cnt_ff + 18'h1;
        end
    end

    // ------------------------------------------------------------------
    // Control / status register
    // ------------------------------------------------------------------
    mcc_ccs_t nxt_ccs;

    always_comb begin
        nxt_ccs = ccs_ff;
        if (wr_ccs && wstrb0_ff) begin
            nxt_ccs = mcc_ccs_t'({wdata_ff[7:1], ccs_ff.time_base_overflow_flag});
        end
        if (rd_ccs) begin
            nxt_ccs.time_base_overflow_flag = 1'b0;
        end
        if (tb_ovf) begin
            nxt_ccs.time_base_overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ccs_ff <= mcc_ccs_t'(CCS_RESET);
        end else if (CE) begin
            ccs_ff <= nxt_ccs;
        end
    end

    wire tb_req = ccs_ff.time_base_overflow_flag && ccs_ff.time_base_irq_enable;

    // ------------------------------------------------------------------
    // Halt sequencer
    // ------------------------------------------------------------------
    mcc_state_t  nxt_state;
    logic [11:0] stab_cnt_ff;
    logic        halt_go;
    logic        wdg_go;
    logic        active_wake;

    wire [11:0] stab_last = stab_long_s ? STAB_LONG_CYC : STAB_SHORT_CYC;
    wire        stab_done = (state_ff == ST_STAB) && pre_tick && (stab_cnt_ff == stab_last);

    always_comb begin
        nxt_state   = state_ff;
        halt_go     = 1'b0;
        wdg_go      = 1'b0;
        active_wake = 1'b0;
        case (state_ff)
            ST_RUN: begin
                if (HALT_REQ && wdg_en_s && !wdg_opt_s) begin
                    wdg_go = 1'b1;
                end else if (HALT_REQ) begin
                    halt_go = 1'b1;
                    if (ccs_ff.time_base_irq_enable) begin
                        nxt_state = ST_ACT_HALT;
                    end else begin
                        nxt_state = ST_FULL_HALT;
                    end
                end
            end
            ST_ACT_HALT: begin
                if (IRQ_PENDING || tb_req) begin
                    active_wake = 1'b1;
                    nxt_state   = ST_RUN;
                end
            end
            ST_FULL_HALT: begin
                if (IRQ_PENDING) begin
                    nxt_state = ST_STAB;
                end
            end
            default: begin
                if (stab_done) begin
                    nxt_state = ST_RUN;
                end
            end
        endcase
    end

    // After reset the sequencer starts in the restart delay with reset cause.
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff       <= ST_STAB;
            cause_reset_ff <= 1'b1;
            stab_cnt_ff    <= 12'h0;
        end else if (CE) begin
            state_ff <= nxt_state;
            if (state_ff == ST_FULL_HALT) begin
                cause_reset_ff <= 1'b0;
                stab_cnt_ff    <= 12'h0;
            end else if (state_ff == ST_STAB && pre_tick) begin
                stab_cnt_ff    <= stab_cnt_ff + 12'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs, registered except OSC_EN, CPU_CLK_EN and IMASK_LEVEL
    // ------------------------------------------------------------------
    logic wake_irq_ff;
    logic wake_rst_ff;
    logic imask_force_ff;
    logic wdg_rst_ff;
    logic clk_out_sel_ff;
    logic tb_irq_ff;

    // Pad mux is selected by a flop, so the pin never sees a half period.
    wire nxt_clk_out_sel = ccs_ff.clock_output_select &&
                           (nxt_state == ST_RUN || nxt_state == ST_STAB);

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wake_irq_ff    <= 1'b0;
            wake_rst_ff    <= 1'b0;
            imask_force_ff <= 1'b0;
            wdg_rst_ff     <= 1'b0;
            clk_out_sel_ff <= 1'b0;
            tb_irq_ff      <= 1'b0;
        end else if (CE) begin
            wake_irq_ff    <= active_wake || (stab_done && !cause_reset_ff);
            wake_rst_ff    <= stab_done && cause_reset_ff;
            imask_force_ff <= halt_go;
            wdg_rst_ff     <= wdg_go;
            clk_out_sel_ff <= nxt_clk_out_sel;
            tb_irq_ff      <= tb_req && !CPU_IMASK_ACTIVE;
        end
    end

    assign WAKE_IRQ_GO               = wake_irq_ff;
    assign WAKE_RESET_GO             = wake_rst_ff;
    assign IMASK_FORCE               = imask_force_ff;
    assign IMASK_LEVEL               = IMASK_HALT_LVL;
    assign WDG_RESET_REQ             = wdg_rst_ff;
    assign CLOCK_OUTPUT_PORT_PIN_SEL = clk_out_sel_ff;
    assign TB_IRQ                    = tb_irq_ff;
    assign OSC_EN                    = (state_ff != ST_FULL_HALT);
    // CPU only clocked in run; halts and restart hold it.
    assign CPU_CLK_EN                = CE && pre_tick && (state_ff == ST_RUN);

endmodule

// ==== mcc_pkg.sv ====
// Shared constants and types of the main clock controller.
// Assumes a single REF_CLK domain at 250 MHz and an AXI4-Lite register port.
package mcc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  CCS_ADDR        = 8'h00;
    localparam logic [7:0]  STAT_ADDR       = 8'h04;
    localparam logic [7:0]  CCS_RESET       = 8'h00;
    localparam int          CCS_MCO_BIT     = 7;
    localparam int          CCS_CP_LSB      = 5;
    localparam int          CCS_SMS_BIT     = 4;
    localparam int          CCS_TB_LSB      = 2;
    localparam int          CCS_OIE_BIT     = 1;
    localparam int          CCS_OIF_BIT     = 0;
    localparam logic [1:0]  AXI_OKAY        = 2'h0;
    localparam logic [1:0]  AXI_SLVERR      = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam logic [11:0] STAB_SHORT_CYC  = 12'hff;   // 256 cycles, counted from 0
    localparam logic [11:0] STAB_LONG_CYC   = 12'hfff;  // 4096 cycles, counted from 0
    localparam logic [1:0]  IMASK_HALT_LVL  = 2'h2;     // Interrupts enabled in halt

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       clock_output_select;
        logic [1:0] slow_clock_divider;
        logic       slow_mode_select;
        logic [1:0] time_base_select;
        logic       time_base_irq_enable;
        logic       time_base_overflow_flag;
    } mcc_ccs_t;

    typedef enum logic [1:0] {
        ST_RUN       = 2'b00,
        ST_ACT_HALT  = 2'b01,
        ST_FULL_HALT = 2'b10,
        ST_STAB      = 2'b11
    } mcc_state_t;

endpackage

// ==== mcc_main_clock_ctrl_assertions.sv ====
// Concurrent checks on the clock controller's CPU, oscillator and pin outputs.
// Assumes the single REF_CLK domain and the active-low ARST_N of the top module.
module mcc_main_clock_ctrl_assertions
    import mcc_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       ARST_N,
    input wire logic       CE,
    input wire logic       HALT_REQ,
    input wire logic       IRQ_PENDING,
    input wire logic       CPU_IMASK_ACTIVE,
    input wire logic       CPU_CLK_EN,
    input wire logic       TB_IRQ,
    input wire logic       IMASK_FORCE,
    input wire logic [1:0] IMASK_LEVEL,
    input wire logic       WAKE_IRQ_GO,
    input wire logic       WAKE_RESET_GO,
    input wire logic       WDG_RESET_REQ,
    input wire logic       OSC_EN,
    input wire logic       CLOCK_OUTPUT_PORT_PIN_SEL
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_imask_level; IMASK_FORCE |-> IMASK_LEVEL == IMASK_HALT_LVL; endproperty
    property p_force_cause; IMASK_FORCE |-> $past(HALT_REQ); endproperty
    property p_halt_clk_stop; !OSC_EN |-> !CPU_CLK_EN; endproperty
    // Pin select is registered, so allow the entry cycle
    property p_halt_pin_off;
        !OSC_EN && !$past(OSC_EN) |-> !CLOCK_OUTPUT_PORT_PIN_SEL;
    endproperty
    property p_osc_restart; !OSC_EN && IRQ_PENDING && CE |=> OSC_EN; endproperty
    property p_stab_quiet; $rose(OSC_EN) |-> (!WAKE_IRQ_GO && !CPU_CLK_EN) [*8]; endproperty
    property p_tb_masked; $past(CPU_IMASK_ACTIVE) && $past(CE) |-> !TB_IRQ; endproperty
    property p_one_cause; !(WAKE_IRQ_GO && WAKE_RESET_GO); endproperty
    property p_wdg_cause; WDG_RESET_REQ |-> $past(HALT_REQ) && OSC_EN; endproperty

    a_imask_level: assert property (p_imask_level) else $error("bad halt mask level");
    a_force_cause: assert property (p_force_cause) else $error("mask force without halt");
    a_halt_clk_stop: assert property (p_halt_clk_stop) else $error("cpu tick in halt");
    a_halt_pin_off: assert property (p_halt_pin_off) else $error("clock out in halt");
    a_osc_restart: assert property (p_osc_restart) else $error("oscillator not restarted");
    a_stab_quiet: assert property (p_stab_quiet) else $error("resume before delay");
    a_tb_masked: assert property (p_tb_masked) else $error("time base irq while masked");
    a_one_cause: assert property (p_one_cause) else $error("two wake causes");
    a_wdg_cause: assert property (p_wdg_cause) else $error("stray watchdog reset");

    c_wake_irq: cover property (WAKE_IRQ_GO);
    c_wdg: cover property (WDG_RESET_REQ);
    c_tb_irq: cover property (TB_IRQ);
endmodule

bind mcc_main_clock_ctrl mcc_main_clock_ctrl_assertions mcc_main_clock_ctrl_assertions_inst (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(CE), .HALT_REQ(HALT_REQ),
    .IRQ_PENDING(IRQ_PENDING), .CPU_IMASK_ACTIVE(CPU_IMASK_ACTIVE),
    .CPU_CLK_EN(CPU_CLK_EN), .TB_IRQ(TB_IRQ), .IMASK_FORCE(IMASK_FORCE),
    .IMASK_LEVEL(IMASK_LEVEL), .WAKE_IRQ_GO(WAKE_IRQ_GO), .WAKE_RESET_GO(WAKE_RESET_GO),
    .WDG_RESET_REQ(WDG_RESET_REQ), .OSC_EN(OSC_EN),
    .CLOCK_OUTPUT_PORT_PIN_SEL(CLOCK_OUTPUT_PORT_PIN_SEL));

// ==== mcc_main_clock_ctrl_test.sv ====
// Self-checking bench for the main clock controller.
// Assumes the design's AXI4-Lite timing and short time base periods for simulation.
module mcc_main_clock_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mcc_pkg::*;

    logic        clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, halt_req = 1'b0, irq_pend = 1'b0;
    logic        imask = 1'b1, stab_long = 1'b0, wdg_en = 1'b0, wdg_opt = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rd;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  rsp;
    wire         awready, wready, bvalid, arready, rvalid, cpu_tick, tb_irq, force_m;
    wire         wake_irq, wake_rst, wdg_rst, osc_en, pin_sel;
    wire  [1:0]  bresp, rresp, lvl;
    wire  [31:0] rdata;
    int          errors = 0, total_checks = 0, n;

    always #2 clk = ~clk;

    mcc_main_clock_ctrl #(.TB_PERIOD_0(20), .TB_PERIOD_1(40), .TB_PERIOD_2(60),
        .TB_PERIOD_3(80)) mcc_main_clock_ctrl_inst (
        .REF_CLK(clk), .ARST_N(arst_n), .CE(1'b1), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .HALT_REQ(halt_req), .IRQ_PENDING(irq_pend),
        .CPU_IMASK_ACTIVE(imask), .CPU_CLK_EN(cpu_tick), .TB_IRQ(tb_irq),
        .IMASK_FORCE(force_m), .IMASK_LEVEL(lvl), .WAKE_IRQ_GO(wake_irq),
        .WAKE_RESET_GO(wake_rst), .STAB_LONG(stab_long), .WDG_ENABLE(wdg_en),
        .WATCHDOG_HALT_OPTION(wdg_opt), .WDG_RESET_REQ(wdg_rst), .OSC_EN(osc_en),
        .CLOCK_OUTPUT_PORT_PIN_SEL(pin_sel));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Handshakes are judged at the falling edge, where ready has settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        logic ta, tr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata[7:0];
            rsp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic halt;
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wait_wake;
        n = 0;
        while (wake_irq !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic gap;
        n = 1;
        @(negedge clk);
        while (cpu_tick !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        n = 0;
        while (wake_rst !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk("reset restart delay", n >= 256 && n <= 270, 1);
        chk("reset wake cause", wake_irq, 1'b0);
    endtask

    task automatic t_regs;
        rd_reg(CCS_ADDR);
        chk("ccs reset", rd & 8'hfe, CCS_RESET & 8'hfe);
        wr(8'h08, 8'hff);
        chk("unmapped write", rsp, AXI_SLVERR);
        rd_reg(8'h08);
        chk("unmapped read", {rd, rsp}, {8'h00, AXI_SLVERR});
        wr(STAT_ADDR, 8'hff);
        chk("status write", rsp, AXI_OKAY);
        rd_reg(STAT_ADDR);
        chk("status read", {rd, rsp}, {8'h04, AXI_OKAY});
        // Low strobe bit must leave the control register untouched
        wstrb <= 4'h0;
        wr(CCS_ADDR, 8'h80);
        chk("strobe off response", rsp, AXI_OKAY);
        rd_reg(CCS_ADDR);
        chk("strobe off write", rd & 8'hfe, 8'h00);
        wstrb <= 4'hf;
    endtask

    // Each divider setting, then normal mode with clock out on
    task automatic t_div;
        logic [7:0] v;
        for (int i = 0; i < 5; i++) begin
            v = (i == 4) ? 8'h80 : {1'b0, 2'(i), 1'b1, 4'h0};
            wr(CCS_ADDR, v);
            gap;
            gap;
            gap;
            chk("cpu clock period", n, (i == 4) ? 1 : 2 << i);
            chk("clock out select", pin_sel, v[7]);
        end
    endtask

    task automatic t_tb;
        wr(CCS_ADDR, 8'h02);
        repeat (30) @(negedge clk);
        chk("masked irq", tb_irq, 1'b0);
        @(posedge clk);
        imask <= 1'b0;
        repeat (2) @(negedge clk);
        chk("unmasked irq", tb_irq, 1'b1);
        rd_reg(CCS_ADDR);
        chk("overflow flag", rd[0], 1'b1);
        @(posedge clk);
        imask <= 1'b1;
    endtask

    task automatic t_active;
        wr(CCS_ADDR, 8'h8e);
        rd_reg(CCS_ADDR);
        halt;
        chk("active halt tick", {cpu_tick, osc_en}, 2'b01);
        @(negedge clk);
        chk("active halt pin", pin_sel, 1'b0);
        wait_wake;
        chk("overflow wakes", n < 200, 1);
    endtask

    task automatic t_full(input logic lng);
        @(posedge clk);
        stab_long <= lng;
        wr(CCS_ADDR, 8'h80);
        halt;
        chk("halt mask force", {force_m, lvl}, 3'b110);
        @(negedge clk);
        chk("full halt", {osc_en, pin_sel, cpu_tick}, 3'b000);
        repeat (100) @(negedge clk);
        chk("no overflow wake", osc_en, 1'b0);
        @(posedge clk);
        irq_pend <= 1'b1;
        @(posedge clk);
        irq_pend <= 1'b0;
        @(negedge clk);
        chk("oscillator restart", osc_en, 1'b1);
        wait_wake;
        chk("restart delay", n >= (lng ? 4094 : 254) && n <= (lng ? 4104 : 264), 1);
        chk("irq resume", wake_rst, 1'b0);
        @(posedge clk);
        stab_long <= 1'b0;
    endtask

    // A pending interrupt at halt entry must not leave the core asleep
    task automatic t_pending;
        @(posedge clk);
        irq_pend <= 1'b1;
        halt;
        repeat (2) @(negedge clk);
        chk("pending wake", osc_en, 1'b1);
        @(posedge clk);
        irq_pend <= 1'b0;
        wait_wake;
        chk("pending resume", n < 5000, 1);
    endtask

    task automatic t_wdg;
        @(posedge clk);
        wdg_en <= 1'b1;
        repeat (3) @(posedge clk);
        halt;
        // The request pulse already stands at the edge halt returns on
        n = 0;
        repeat (6) begin
            if (wdg_rst === 1'b1) n++;
            @(negedge clk);
        end
        chk("watchdog reset", {n[1:0], osc_en}, 3'b011);
        @(posedge clk);
        wdg_opt <= 1'b1;
        repeat (3) @(posedge clk);
        halt;
        @(negedge clk);
        chk("halt allowed", {osc_en, wdg_rst}, 2'b00);
        @(posedge clk);
        irq_pend <= 1'b1;
        @(posedge clk);
        irq_pend <= 1'b0;
        wdg_en <= 1'b0;
        wait_wake;
        chk("watchdog halt wake", wake_irq, 1'b1);
    endtask

    initial begin
        #100us;
        errors++;
        finish_test;
    end

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_regs;
        t_div;
        t_tb;
        t_active;
        t_full(1'b0);
        t_full(1'b1);
        t_pending;
        t_wdg;
        finish_test;
    end
endmodule
